// ### dmah_params.svh
// constants for the halt-mode transfer sequencer
`ifndef DMAH_PARAMS_SVH
`define DMAH_PARAMS_SVH

`define DMAH_NUM_CH       4
`define DMAH_FIFO_DEPTH   4
`define DMAH_CNT_ZERO     16'h0000
`define DMAH_ADR_STEP     16'h0001

// register index map
`define DMAH_REG_ICR      6'h20
`define DMAH_REG_DCR      6'h21
`define DMAH_FLD_ADR_HI   3'h0
`define DMAH_FLD_ADR_LO   3'h1
`define DMAH_FLD_CNT_HI   3'h2
`define DMAH_FLD_CNT_LO   3'h3
`define DMAH_FLD_CTL      3'h4

// channel control bits
`define DMAH_CTL_RW       0
`define DMAH_CTL_BURST    1
`define DMAH_CTL_TSC      2
`define DMAH_CTL_DOWN     3
`define DMAH_CTL_BUSY     6
`define DMAH_CTL_END      7

// interrupt control bits
`define DMAH_ICR_FLAG     7

// chain control bits
`define DMAH_DCR_CHAIN_EN 0
`define DMAH_DCR_TGT_LO   1
`define DMAH_DCR_TGT_HI   2
`define DMAH_DCR_FOUR_CH  3
`define DMAH_DCR_TGT_NONE 2'h3

`define DMAH_ICR_RESET    8'h00
`define DMAH_DCR_RESET    8'h00

`endif

// ### dmah_pkg.sv
// types shared by the halt-mode transfer sequencer
package dmah_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_GRANT,
    ST_DRIVE,
    ST_STROBE,
    ST_BWAIT,
    ST_RELEASE
  } dmah_state_t;

  // one completed byte transfer
  typedef struct packed {
    logic [1:0]  chan;
    logic        rw;
    logic [15:0] addr;
  } dmah_log_t;

  // per-channel mode bits
  typedef struct packed {
    logic down;
    logic three_state_steal;
    logic burst;
    logic rw;
  } dmah_mode_t;

endpackage : dmah_pkg

// ### dmah_sequencer.sv
// halt-mode transfer sequencer with its transfer-log fifo
`timescale 1ns/1ps
`include "dmah_params.svh"

module dmah_fifo
  import dmah_pkg::*;
#(
  parameter int WIDTH = 19,
  parameter int DEPTH = 4
)
(
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [CW-1:0]    cnt_q;
  logic [CW-1:0]    cnt_d;
  logic             push;
  logic             pop;

  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_ptr_q];

  always_comb
  begin
    cnt_d = cnt_q;
    if (push && !pop)
      cnt_d = cnt_q + CW'(1);
    else if (pop && !push)
      cnt_d = cnt_q - CW'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_q[wr_ptr_q] <= in_data_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      wr_ptr_q    <= '0;
      rd_ptr_q    <= '0;
      cnt_q       <= '0;
      out_valid_o <= 1'b0;
      in_ready_o  <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + PW'(1);
      if (pop)
        rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + PW'(1);
      cnt_q       <= cnt_d;
      out_valid_o <= (cnt_d != '0);
      in_ready_o  <= (cnt_d != CW'(DEPTH));
    end
  end
endmodule : dmah_fifo

// Behaviour
// RULE1 - icr bits 0-3 enable per-channel interrupts
// RULE2 - icr bit 7 reads interrupt output active
// RULE3 - chain control bit 0 enables chaining
// RULE4 - chaining copies channel 3 address, count
// RULE5 - bits 1,2 pick chain target channel
// RULE6 - bit 3 four-channel mode, pin bidirectional
// RULE7 - halt steal, halt burst, three-state steal modes
// RULE8 - request sampled on phase-2 rising edge
// RULE9 - accept: halt request low, then ack A
// RULE10 - after grant drive ack B, address, rw
// RULE11 - strobe byte, step address, decrement count
// RULE12 - cycle steal releases halt after each byte
// RULE13 - cycle steal floats lines, grant then falls
// RULE14 - peripheral requests once per byte, drops
// RULE15 - request drop before grant: hold, wait
// RULE16 - request still high after strobe restarts
// RULE17 - burst holds halt low until count zero
// RULE18 - burst samples request on phase-2 falling edge
// RULE19 - burst end: block end low, float, grant falls
// RULE20 - steady burst request moves byte per cycle
// RULE21 - peripheral drops request when strobe low
// RULE22 - interrupt is OR of flag and enable; code ORs each end flag ANDed with its enable
// RULE23 - end flag set at zero, read clears
// RULE24 - three-state channels cannot use burst
// RULE25 - four-channel pin: select in, ack B out
// RULE26 - undefined target performs no chain load
module dmah_sequencer
  import dmah_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        dma_phase2_clock_i,
  input  wire logic [3:0]  xfer_request_i,
  input  wire logic        bus_grant_i,
  output logic             halt_request_n_o,
  output logic             tristate_request_n_o,
  output logic             xfer_ack_a_o,
  output logic             xfer_strobe_o,
  output logic             irq_or_block_end_n_o,
  output logic [1:0]       xfer_chan_o,
  output logic [15:0]      addr_o,
  output logic             addr_oe_n_o,
  output logic             rw_o,
  output logic             rw_oe_n_o,
  input  wire logic        select_or_ack_b_pin_i,
  output logic             select_or_ack_b_pin_o,
  output logic             select_or_ack_b_pin_oe_n_o,
  input  wire logic [5:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic [7:0]       reg_rdata_o,
  output logic             log_valid_o,
  input  wire logic        log_ready_i,
  output dmah_log_t        log_data_o
);

  dmah_state_t state_q;
  logic [15:0] adr_q [`DMAH_NUM_CH];
  logic [15:0] cnt_q [`DMAH_NUM_CH];
  dmah_mode_t  mode_q [`DMAH_NUM_CH];
  logic [3:0]  busy_q;
  logic [3:0]  end_q;
  logic [7:0]  icr_q;
  logic [7:0]  dcr_q;
  logic [1:0]  ch_q;
  logic        ph2_prev_q;
  logic        ph2_rise;
  logic        ph2_fall;
  logic        cs_ok;
  logic        wr_hit;
  logic        rd_hit;
  logic [1:0]  reg_ch;
  logic [2:0]  reg_fld;
  logic        last_byte;
  logic        steal;
  logic        fifo_ready;
  logic        push;
  logic [1:0]  tgt;
  logic        chain_load;
  logic [3:0]  irq_vec;
  dmah_log_t   log_word;

  function automatic logic [1:0] pick_chan(input logic [3:0] req);
    pick_chan = 2'h3;
    for (int i = `DMAH_NUM_CH - 1; i >= 0; i--)
      if (req[i])
        pick_chan = 2'(i);
  endfunction : pick_chan

  function automatic logic [15:0] step_adr(input logic [15:0] a,
                                           input logic        down);
    step_adr = down ? a - `DMAH_ADR_STEP : a + `DMAH_ADR_STEP;
  endfunction : step_adr

  assign ph2_rise  = dma_phase2_clock_i && !ph2_prev_q;
  assign ph2_fall  = !dma_phase2_clock_i && ph2_prev_q;
  // in four-channel mode the pin is a select only while the cpu owns the bus
  assign cs_ok     = !select_or_ack_b_pin_i &&
                     !(dcr_q[`DMAH_DCR_FOUR_CH] && bus_grant_i); // see RULE25
  assign wr_hit    = reg_wr_i && cs_ok;
  assign rd_hit    = reg_rd_i && cs_ok;
  assign reg_ch    = reg_addr_i[4:3];
  assign reg_fld   = reg_addr_i[2:0];
  // the block ends with the byte that takes the count to zero
  assign last_byte = ((cnt_q[ch_q] - `DMAH_ADR_STEP) == `DMAH_CNT_ZERO);
  // three-state channels never burst
  assign steal     = !mode_q[ch_q].burst || mode_q[ch_q].three_state_steal; // see RULE24
  assign push      = (state_q == ST_STROBE);
  assign tgt       = {dcr_q[`DMAH_DCR_TGT_HI], dcr_q[`DMAH_DCR_TGT_LO]}; // see RULE5
  assign chain_load = push && last_byte && dcr_q[`DMAH_DCR_CHAIN_EN] &&
                      tgt != `DMAH_DCR_TGT_NONE && tgt == ch_q; // see RULE3 RULE26
  assign irq_vec   = end_q & icr_q[3:0]; // see RULE1 RULE22

  always_comb
  begin
    log_word.chan = ch_q;
    log_word.rw   = mode_q[ch_q].rw;
    log_word.addr = adr_q[ch_q];
  end

  // tracks the pin through reset so no false edge follows release
  always_ff @(posedge clk_i)
  begin
    ph2_prev_q <= dma_phase2_clock_i;
  end

  // transfer sequence
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      state_q <= ST_IDLE;
      ch_q    <= 2'h0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
          if (ph2_rise && xfer_request_i != 4'h0) // see RULE8 RULE16
          begin
            ch_q    <= pick_chan(xfer_request_i);
            state_q <= ST_REQ;
          end
        ST_REQ:
          state_q <= ST_GRANT; // see RULE9
        ST_GRANT:
          // a dropped request keeps the cpu halted until it returns
          if (bus_grant_i && xfer_request_i[ch_q] && fifo_ready) // see RULE15
            state_q <= ST_DRIVE; // see RULE10
        ST_DRIVE:
          state_q <= ST_STROBE;
        ST_STROBE:
          if (last_byte || steal)
            state_q <= ST_RELEASE; // see RULE12 RULE17
          else
            state_q <= ST_BWAIT;
        ST_BWAIT:
          if (ph2_fall && xfer_request_i[ch_q] && fifo_ready) // see RULE18
            state_q <= ST_STROBE; // see RULE20
        ST_RELEASE:
          if (!bus_grant_i)
            state_q <= ST_IDLE; // see RULE13 RULE19
      endcase
    end
  end

  // pin drivers
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      halt_request_n_o           <= 1'b1;
      tristate_request_n_o       <= 1'b1;
      xfer_ack_a_o               <= 1'b0;
      xfer_strobe_o              <= 1'b0;
      xfer_chan_o                <= 2'h0;
      addr_o                     <= 16'h0000;
      addr_oe_n_o                <= 1'b1;
      rw_o                       <= 1'b0;
      rw_oe_n_o                  <= 1'b1;
      select_or_ack_b_pin_o      <= 1'b0;
      select_or_ack_b_pin_oe_n_o <= 1'b1;
    end
    else
    begin
      xfer_strobe_o <= 1'b0;
      unique case (state_q)
        ST_REQ:
        begin
          // three-state channels use their own request line
          halt_request_n_o     <= mode_q[ch_q].three_state_steal; // see RULE7 RULE9
          tristate_request_n_o <= !mode_q[ch_q].three_state_steal;
          xfer_ack_a_o         <= 1'b1;
          xfer_chan_o          <= ch_q;
        end
        ST_DRIVE, ST_BWAIT:
        begin
          addr_o                     <= adr_q[ch_q]; // see RULE10
          addr_oe_n_o                <= 1'b0;
          rw_o                       <= mode_q[ch_q].rw;
          rw_oe_n_o                  <= 1'b0;
          select_or_ack_b_pin_o      <= 1'b1;
          select_or_ack_b_pin_oe_n_o <= !dcr_q[`DMAH_DCR_FOUR_CH]; // see RULE6
          if (state_q == ST_BWAIT && ph2_fall &&
              xfer_request_i[ch_q] && fifo_ready)
            xfer_strobe_o <= 1'b1;
          else if (state_q == ST_DRIVE)
            xfer_strobe_o <= 1'b1; // see RULE11
        end
        ST_STROBE:
          addr_o <= step_adr(adr_q[ch_q], mode_q[ch_q].down);
        ST_RELEASE:
        begin
          halt_request_n_o           <= 1'b1; // see RULE12 RULE17
          tristate_request_n_o       <= 1'b1;
          xfer_ack_a_o               <= 1'b0;
          addr_oe_n_o                <= 1'b1; // see RULE13
          rw_oe_n_o                  <= 1'b1;
          select_or_ack_b_pin_o      <= 1'b0;
          select_or_ack_b_pin_oe_n_o <= 1'b1; // see RULE25
        end
        default:
        begin
        end
      endcase
    end
  end

  // interrupt and block-end output
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      irq_or_block_end_n_o <= 1'b1;
    else if (push && last_byte)
      irq_or_block_end_n_o <= 1'b0; // see RULE19
    else
      irq_or_block_end_n_o <= !(|irq_vec); // see RULE22
  end

  // address, count and mode registers; chaining
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < `DMAH_NUM_CH; i++)
      begin
        adr_q[i]  <= 16'h0000;
        cnt_q[i]  <= 16'h0000;
        mode_q[i] <= '0;
      end
    end
    else
    begin
      if (wr_hit && !reg_addr_i[5])
      begin
        unique case (reg_fld)
          `DMAH_FLD_ADR_HI: adr_q[reg_ch][15:8] <= reg_wdata_i;
          `DMAH_FLD_ADR_LO: adr_q[reg_ch][7:0]  <= reg_wdata_i;
          `DMAH_FLD_CNT_HI: cnt_q[reg_ch][15:8] <= reg_wdata_i;
          `DMAH_FLD_CNT_LO: cnt_q[reg_ch][7:0]  <= reg_wdata_i;
          `DMAH_FLD_CTL:
            mode_q[reg_ch] <= {reg_wdata_i[`DMAH_CTL_DOWN],
                               reg_wdata_i[`DMAH_CTL_TSC],
                               reg_wdata_i[`DMAH_CTL_BURST],
                               reg_wdata_i[`DMAH_CTL_RW]};
          default:
          begin
          end
        endcase
      end
      if (push)
      begin
        adr_q[ch_q] <= step_adr(adr_q[ch_q], mode_q[ch_q].down); // see RULE11
        cnt_q[ch_q] <= cnt_q[ch_q] - `DMAH_ADR_STEP;
      end
      if (chain_load)
      begin
        adr_q[ch_q] <= adr_q[3]; // see RULE4
        cnt_q[ch_q] <= cnt_q[3];
      end
    end
  end

  // busy and end-of-block flags; a set wins over a read clear
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      busy_q <= 4'h0;
      end_q  <= 4'h0;
    end
    else
    begin
      if (rd_hit && !reg_addr_i[5] && reg_fld == `DMAH_FLD_CTL)
        end_q[reg_ch] <= 1'b0; // see RULE23
      if (state_q == ST_REQ)
        busy_q[ch_q] <= 1'b1;
      if (push && last_byte)
      begin
        end_q[ch_q]  <= 1'b1; // see RULE23
        busy_q[ch_q] <= 1'b0;
      end
    end
  end

  // interrupt control and chain control
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      icr_q <= `DMAH_ICR_RESET;
      dcr_q <= `DMAH_DCR_RESET;
    end
    else if (wr_hit && reg_addr_i == `DMAH_REG_ICR)
      icr_q <= {4'h0, reg_wdata_i[3:0]}; // see RULE1 RULE2
    else if (wr_hit && reg_addr_i == `DMAH_REG_DCR)
      dcr_q <= {4'h0, reg_wdata_i[3:0]}; // see RULE3 RULE6
  end

  // register read port
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      reg_rdata_o <= 8'h00;
    else if (rd_hit)
    begin
      reg_rdata_o <= 8'h00;
      if (reg_addr_i == `DMAH_REG_ICR)
      begin
        reg_rdata_o                 <= icr_q;
        reg_rdata_o[`DMAH_ICR_FLAG] <= !irq_or_block_end_n_o; // see RULE2
      end
      else if (reg_addr_i == `DMAH_REG_DCR)
        reg_rdata_o <= dcr_q;
      else if (!reg_addr_i[5])
      begin
        unique case (reg_fld)
          `DMAH_FLD_ADR_HI: reg_rdata_o <= adr_q[reg_ch][15:8];
          `DMAH_FLD_ADR_LO: reg_rdata_o <= adr_q[reg_ch][7:0];
          `DMAH_FLD_CNT_HI: reg_rdata_o <= cnt_q[reg_ch][15:8];
          `DMAH_FLD_CNT_LO: reg_rdata_o <= cnt_q[reg_ch][7:0];
          `DMAH_FLD_CTL:
          begin
            reg_rdata_o[`DMAH_CTL_RW]    <= mode_q[reg_ch].rw;
            reg_rdata_o[`DMAH_CTL_BURST] <= mode_q[reg_ch].burst;
            reg_rdata_o[`DMAH_CTL_TSC]   <= mode_q[reg_ch].three_state_steal;
            reg_rdata_o[`DMAH_CTL_DOWN]  <= mode_q[reg_ch].down;
            reg_rdata_o[`DMAH_CTL_BUSY]  <= busy_q[reg_ch];
            reg_rdata_o[`DMAH_CTL_END]   <= end_q[reg_ch];
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // each moved byte is logged; a full log stalls the next strobe
  dmah_fifo #(
    .WIDTH ($bits(dmah_log_t)),
    .DEPTH (`DMAH_FIFO_DEPTH)
  ) u_log (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (log_word),
    .out_valid_o (log_valid_o),
    .out_ready_i (log_ready_i),
    .out_data_o  (log_data_o)
  );

endmodule : dmah_sequencer

// ### dmah_sequencer_sva.sv
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
module dmah_sequencer_sva (
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic [3:0] xfer_request_i,
  input wire logic       bus_grant_i,
  input wire logic       halt_request_n_o,
  input wire logic       tristate_request_n_o,
  input wire logic       xfer_ack_a_o,
  input wire logic       xfer_strobe_o,
  input wire logic       addr_oe_n_o,
  input wire logic       rw_oe_n_o,
  input wire logic       select_or_ack_b_pin_oe_n_o,
  input wire logic       log_valid_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  halt_ack_a: assert property (!halt_request_n_o |-> xfer_ack_a_o)
    else $error("ack A low while halt requested");
  strobe_grant_a: assert property (xfer_strobe_o |->
    bus_grant_i && !addr_oe_n_o && !rw_oe_n_o)
    else $error("strobe without grant or driven lines");
  strobe_pulse_a: assert property (xfer_strobe_o |=> !xfer_strobe_o)
    else $error("strobe longer than one cycle");
  strobe_held_a: assert property (xfer_strobe_o |->
    !(halt_request_n_o && tristate_request_n_o))
    else $error("strobe while no request to the processor");
  release_float_a: assert property ($rose(halt_request_n_o) |->
    addr_oe_n_o && rw_oe_n_o)
    else $error("lines still driven at halt release");
  ackb_grant_a: assert property (!select_or_ack_b_pin_oe_n_o |->
    bus_grant_i)
    else $error("ack B driven without grant");
  no_request_a: assert property ((xfer_request_i == 4'h0)[*3] |=>
    !xfer_strobe_o)
    else $error("strobe without a pending request");
  strobe_log_a: assert property (xfer_strobe_o |-> ##[1:4] log_valid_o)
    else $error("transfer not logged");
endmodule : dmah_sequencer_sva

// ### dmah_peer_model.sv
// grant logic and peripheral request model facing the sequencer
`timescale 1ns/1ps
module dmah_peer_model (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       halt_n_i,
  input  wire logic       strobe_i,
  input  wire logic [1:0] chan_i,
  input  wire logic [3:0] raise_i,
  input  wire logic       hold_i,
  input  wire logic       slow_i,
  output logic            grant_o,
  output logic      [3:0] req_o
);
  logic [2:0] wait_q;

  // grant comes promptly or late, falls once halt is released
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || halt_n_i)
    begin
      wait_q  <= 3'h0;
      grant_o <= 1'b0;
    end
    else
    begin
      wait_q  <= wait_q + {2'h0, wait_q != 3'h7};
      grant_o <= wait_q >= (slow_i ? 3'h4 : 3'h0);
    end
  end

  // one request per byte unless held as a level
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      req_o <= 4'h0;
    else
      for (int c = 0; c < 4; c++)
        if (raise_i[c])
          req_o[c] <= 1'b1;
        else if (strobe_i && chan_i == c[1:0] && !hold_i)
          req_o[c] <= 1'b0;
  end
endmodule : dmah_peer_model

// ### testbench.sv
// self-checking bench for the halt-mode transfer sequencer
`timescale 1ns/1ps
`include "dmah_params.svh"
module testbench
  import dmah_pkg::*;
;
  logic       clk = 1'b0, rstn = 1'b0, hold = 1'b0, slow = 1'b0;
  logic       cs_n = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, log_ready = 1'b1;
  logic [1:0] p2c = 2'h0, chan;
  logic [3:0] req, raise = 4'h0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00, rdata;
  logic [15:0] addr;
  logic       gnt, halt_n, tri_n, ack_a, strobe, irq_n, addr_oe_n;
  logic       rw, rw_oe_n, pin_o, pin_oe_n, log_valid;
  wire        pin = pin_oe_n ? cs_n : pin_o;
  dmah_log_t  log_data;
  int         bad_count = 0, checks = 0;

  always #12.5 clk = ~clk;
  always @(negedge clk) p2c <= p2c + 2'h1;

  dmah_sequencer dmah_sequencer_inst (
    .clk_i(clk), .rstn_i(rstn), .dma_phase2_clock_i(p2c[1]),
    .xfer_request_i(req), .bus_grant_i(gnt),
    .halt_request_n_o(halt_n), .tristate_request_n_o(tri_n),
    .xfer_ack_a_o(ack_a), .xfer_strobe_o(strobe),
    .irq_or_block_end_n_o(irq_n), .xfer_chan_o(chan), .addr_o(addr),
    .addr_oe_n_o(addr_oe_n), .rw_o(rw), .rw_oe_n_o(rw_oe_n),
    .select_or_ack_b_pin_i(pin), .select_or_ack_b_pin_o(pin_o),
    .select_or_ack_b_pin_oe_n_o(pin_oe_n), .reg_addr_i(reg_addr),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata),
    .reg_rdata_o(rdata), .log_valid_o(log_valid),
    .log_ready_i(log_ready), .log_data_o(log_data)
  );

  dmah_peer_model dmah_peer_model_inst (
    .clk_i(clk), .rstn_i(rstn), .halt_n_i(halt_n & tri_n),
    .strobe_i(strobe), .chan_i(chan), .raise_i(raise), .hold_i(hold),
    .slow_i(slow), .grant_o(gnt), .req_o(req)
  );

  task automatic tally_and_finish;
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // sel 0 both processor requests, 1 strobe, 2 log valid
  task automatic wait_on(input int sel, input logic lvl);
    int n;
    n = 0;
    while ((sel == 0 ? halt_n & tri_n : sel == 1 ? strobe : log_valid)
           !== lvl)
    begin
      @(negedge clk);
      n++;
      if (n > 300)
      begin
        bad_count++;
        $display("FAIL %0t wait ran out", $time);
        tally_and_finish();
      end
    end
  endtask : wait_on

  task automatic acc(input logic [5:0] a, input logic w, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wr = w;
    reg_rd = !w;
    reg_wdata = d;
    cs_n = 1'b0;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cs_n = 1'b1;
    @(negedge clk);
  endtask : acc

  task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
    acc(a, 1'b0, 8'h00);
    chk({8'h00, rdata}, {8'h00, e});
  endtask : rdchk

  task automatic setch(input logic [1:0] n, input logic [15:0] a,
                       input logic [15:0] c, input logic [7:0] m);
    acc({1'b0, n, 3'h0}, 1'b1, a[15:8]);
    acc({1'b0, n, 3'h1}, 1'b1, a[7:0]);
    acc({1'b0, n, 3'h2}, 1'b1, c[15:8]);
    acc({1'b0, n, 3'h3}, 1'b1, c[7:0]);
    acc({1'b0, n, 3'h4}, 1'b1, m);
  endtask : setch

  task automatic t_regs;
    acc(`DMAH_REG_ICR, 1'b1, 8'hFF);
    rdchk(`DMAH_REG_ICR, 8'h0F);
    acc(`DMAH_REG_DCR, 1'b1, 8'hFF);
    rdchk(`DMAH_REG_DCR, 8'h0F);
    rdchk(6'h3F, 8'h00);
    acc(`DMAH_REG_DCR, 1'b1, 8'h00);
  endtask : t_regs

  // steal bytes with a late grant while the log fills and refuses
  task automatic t_steal;
    logic [15:0] n;
    setch(2'h0, 16'h1000, 16'h0010, 8'h00);
    log_ready = 1'b0;
    slow = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      raise = 4'h1;
      @(negedge clk);
      raise = 4'h0;
      if (i < 4)
      begin
        wait_on(1, 1'b1);
        chk(addr, 16'h1000 + i[15:0]);
        wait_on(0, 1'b1);
        chk({15'h0000, addr_oe_n & rw_oe_n}, 16'h0001);
      end
    end
    n = 16'h0000;
    repeat (40)
    begin
      @(negedge clk);
      n = n + {15'h0000, strobe};
    end
    chk(n, 16'h0000);
    log_ready = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      wait_on(2, 1'b1);
      chk(log_data.addr, 16'h1000 + i[15:0]);
      @(negedge clk);
    end
    wait_on(0, 1'b1);
    rdchk(6'h01, 8'h05);
    rdchk(6'h03, 8'h0B);
  endtask : t_steal

  // burst on channel 1 with a level request, chaining from channel 3
  task automatic t_burst;
    acc(`DMAH_REG_ICR, 1'b1, 8'h02);
    acc(`DMAH_REG_DCR, 1'b1, 8'h03);
    setch(2'h3, 16'h2000, 16'h0005, 8'h00);
    setch(2'h1, 16'h3000, 16'h0002, 8'h02);
    slow = 1'b0;
    hold = 1'b1;
    raise = 4'h2;
    @(negedge clk);
    raise = 4'h0;
    wait_on(1, 1'b1);
    @(negedge clk);
    chk({15'h0000, halt_n}, 16'h0000);
    wait_on(1, 1'b1);
    hold = 1'b0;
    chk(addr, 16'h3001);
    wait_on(0, 1'b1);
    chk({15'h0000, irq_n}, 16'h0000);
    rdchk(`DMAH_REG_ICR, 8'h82);
    rdchk(6'h08, 8'h20);
    rdchk(6'h0B, 8'h05);
    rdchk(6'h0C, 8'h82);
    chk({15'h0000, irq_n}, 16'h0001);
    rdchk(`DMAH_REG_ICR, 8'h02);
  endtask : t_burst

  // three-state channel 3 in four-channel mode, undefined chain target
  task automatic t_tsc;
    acc(`DMAH_REG_ICR, 1'b1, 8'h08);
    acc(`DMAH_REG_DCR, 1'b1, 8'h0F);
    setch(2'h3, 16'h5000, 16'h0002, 8'h0F);
    for (int i = 0; i < 2; i++)
    begin
      raise = 4'h8;
      @(negedge clk);
      raise = 4'h0;
      wait_on(1, 1'b1);
      chk({14'h0000, halt_n, tri_n}, 16'h0002);
      chk({14'h0000, pin_oe_n, pin_o}, 16'h0001);
      chk({15'h0000, rw}, 16'h0001);
      chk(addr, 16'h5000 - i[15:0]);
      wait_on(0, 1'b1);
      chk({15'h0000, pin_oe_n}, 16'h0001);
      rdchk(6'h1B, 8'h01 - i[7:0]);
    end
    chk({15'h0000, irq_n}, 16'h0000);
    rdchk(`DMAH_REG_ICR, 8'h88);
    rdchk(6'h19, 8'hFE);
  endtask : t_tsc

  initial
  begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    t_regs();
    t_steal();
    t_burst();
    t_tsc();
    tally_and_finish();
  end
endmodule : testbench

bind dmah_sequencer dmah_sequencer_sva dmah_sequencer_sva_inst (.*);
